// [src/ata_read_command_exec.sv]
// Purpose: Task-file command execution for the read command group
// Assumes: Media fetch logic on pclk; DMA strobes arrive from pins
// Notes:   APB slave, one wait state on every access
`timescale 1ns/1ps
module ata_read_command_exec #(
   parameter int CHS_HEADS    = 16,
   parameter int CHS_SECTORS  = 63
) (
   input  wire  logic        pclk,
   input  wire  logic        presetn,
   input  wire  logic [11:0] paddr,
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [31:0] pwdata,
   output logic       [31:0] prdata,
   output logic              pready,
   output logic              pslverr,
   output logic              dma_request_line,
   input  wire  logic        dma_acknowledge_n,
   input  wire  logic        io_read_strobe_n,
   output logic       [15:0] dma_data,
   output logic              host_intrq,
   output logic              med_req,
   output logic       [27:0] med_addr,
   output logic              med_lba_mode,
   input  wire  logic [15:0] med_word,
   input  wire  logic        med_word_valid,
   input  wire  logic        med_done,
   input  wire  logic [31:0] med_ecc,
   input  wire  ata_read_pkg::med_err_e med_err,
   output logic              km_change_strobe
);
   import ata_read_pkg::*;
   if (CHS_HEADS < 1 || CHS_HEADS > 16 || CHS_SECTORS < 1 || CHS_SECTORS > 255) begin : g_geom_chk
      $error("Unsupported geometry");
   end
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   seq_state_e  state_q;
   cmd_kind_e   kind_q;
   logic [7:0]  fea_q, cnt_q, snum_q, cyl_lo_q, cyl_hi_q, dh_q, err_q;
   logic        busy_q, drq_q, errbit_q, corr_q, irq_q;
   logic        eight_q, mult_en_q, mult_set_q;
   logic [7:0]  blk_size_q;
   logic [8:0]  sect_left_q, blk_pos_q, idx_q, fill_idx_q;
   logic [2:0]  ecc_idx_q;
   logic [31:0] ecc_q;
   logic        stop_q, pready_q, pslverr_q, med_req_q, km_q;
   logic [15:0] buf_mem [0:255];
   logic [31:0] prdata_q;
   logic [15:0] dma_data_q;
   logic [2:0]  strb_sync_q;
   logic [1:0]  ack_sync_q;
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic        setup, acc, rd_acc, wr_acc, mapped;
   logic [3:0]  idx;
   logic        pio_pop, dma_pop, word_pop, ecc_pop;
   logic        sector_end, final_sector, block_end;
   logic [8:0]  blk_len, req_count;
   logic [27:0] lba_next;
   logic        last_word;
   assign idx       = paddr[5:2];
   assign mapped    = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00) && (idx <= IDX_ERROR);
   assign setup     = psel && penable && !pready_q;
   assign acc       = psel && penable && pready_q;
   assign rd_acc    = acc && !pwrite && mapped;
   assign wr_acc    = acc && pwrite && mapped;
   assign blk_len   = (blk_size_q == 8'h00) ? MAX_SECTORS : {1'b0, blk_size_q};
   assign req_count = (cnt_q == 8'h00) ? MAX_SECTORS : {1'b0, cnt_q};
   // PIO pops on data reads; DMA pops on a strobe fall with acknowledge
   assign pio_pop   = rd_acc && (idx == IDX_DATA) && drq_q && (kind_q != K_DMA) && (state_q == ST_XFER);
   assign dma_pop   = (state_q == ST_XFER) && (kind_q == K_DMA) && drq_q && !ack_sync_q[1]
                      && strb_sync_q[2] && !strb_sync_q[1];
   assign word_pop  = (pio_pop || dma_pop) && (idx_q < WORDS_PER_SECT);
   assign ecc_pop   = pio_pop && (kind_q == K_LONG) && (idx_q == WORDS_PER_SECT);
   assign last_word = word_pop && (idx_q == WORDS_PER_SECT - 9'h001);
   assign sector_end = (kind_q == K_LONG) ? (ecc_pop && ecc_idx_q == ECC_BYTES - 3'h1) : last_word;
   assign final_sector = (sect_left_q == 9'h001);
   assign block_end = (blk_pos_q == blk_len - 9'h001);
   // LOGICAL_BLOCK_ADDRESSING increment over the split task-file fields
   assign lba_next  = {dh_q[3:0], cyl_hi_q, cyl_lo_q, snum_q} + 28'h0000001;
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strb_sync_q <= 3'b111;
         ack_sync_q  <= 2'b11;
      end else begin
         strb_sync_q <= {strb_sync_q[1:0], io_read_strobe_n};
         ack_sync_q  <= {ack_sync_q[0], dma_acknowledge_n};
      end
   end
   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !mapped;
         if (setup && !pwrite) begin
            case (idx)
               IDX_DATA:       prdata_q <= (kind_q == K_LONG && idx_q == WORDS_PER_SECT) ?
                                           {24'h000000, ecc_q[8*ecc_idx_q[1:0] +: 8]} :
                                           {16'h0000, buf_mem[idx_q[7:0]]};
               IDX_SECT_CNT:   prdata_q <= {24'h000000, cnt_q};
               IDX_SECT_NUM:   prdata_q <= {24'h000000, snum_q};
               IDX_CYL_LOW:    prdata_q <= {24'h000000, cyl_lo_q};
               IDX_CYL_HIGH:   prdata_q <= {24'h000000, cyl_hi_q};
               IDX_DRIVE_HEAD: prdata_q <= {24'h000000, dh_q};
               IDX_CONFIG:     prdata_q <= {16'h0000, blk_size_q, 5'h00, mult_set_q, mult_en_q, eight_q};
               IDX_STATUS:     prdata_q <= {24'h000000, busy_q, !busy_q, 2'b00, drq_q, corr_q, 1'b0, errbit_q};
               IDX_ERROR:      prdata_q <= {24'h000000, err_q};
               default:        prdata_q <= 32'h00000000;
            endcase
         end
      end
   end
   // ----------------------------------------------------------------
   // Sector buffer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk) begin
      if (state_q == ST_FILL && med_word_valid && fill_idx_q < WORDS_PER_SECT) begin
         buf_mem[fill_idx_q[7:0]] <= med_word;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_data_q <= 16'h0000;
      end else if (dma_pop && idx_q < WORDS_PER_SECT) begin
         dma_data_q <= buf_mem[idx_q[7:0]];
      end
   end
   // ----------------------------------------------------------------
   // Configuration register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eight_q    <= 1'b0;
         mult_en_q  <= 1'b0;
         mult_set_q <= 1'b0;
         blk_size_q <= RST_ZERO;
      end else if (wr_acc && idx == IDX_CONFIG) begin
         eight_q    <= pwdata[CFG_EIGHT_BIT];
         mult_en_q  <= pwdata[CFG_MULT_EN_BIT];
         mult_set_q <= pwdata[CFG_MULT_SET_BIT];
         blk_size_q <= pwdata[CFG_BLK_LSB +: 8];
      end
   end
   // ----------------------------------------------------------------
   // Interrupt line: set wins over the clear by a status read
   // ----------------------------------------------------------------
   logic irq_set;
   assign irq_set = (state_q == ST_FILL && med_done && (kind_q == K_PIO || kind_q == K_LONG ||
                     med_err == MED_UNCORRECTABLE || (kind_q == K_MULT && blk_pos_q == 9'h000)))
                 || (state_q == ST_XFER && sector_end && kind_q == K_DMA && final_sector)
                 || (wr_acc && idx == IDX_COMMAND && !busy_q && !drq_q &&
                     !(pwdata[7:0] inside {OP_READ_SECT, OP_READ_SECT_NR, OP_READ_LONG, OP_READ_LONG_NR}) &&
                     !(pwdata[7:0] == OP_READ_MULT && mult_set_q && mult_en_q) &&
                     !(pwdata[7:0] == OP_READ_DMA && !eight_q));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else if (irq_set) begin
         irq_q <= 1'b1;
      end else if (rd_acc && idx == IDX_STATUS) begin
         irq_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Command sequencer and task file
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= ST_IDLE;
         kind_q      <= K_PIO;
         fea_q       <= RST_ZERO;
         cnt_q       <= RST_SECT_NUM;
         snum_q      <= RST_SECT_NUM;
         cyl_lo_q    <= RST_ZERO;
         cyl_hi_q    <= RST_ZERO;
         dh_q        <= RST_DRIVE_HEAD;
         err_q       <= RST_ZERO;
         busy_q      <= 1'b0;
         drq_q       <= 1'b0;
         errbit_q    <= 1'b0;
         corr_q      <= 1'b0;
         sect_left_q <= 9'h000;
         blk_pos_q   <= 9'h000;
         idx_q       <= 9'h000;
         fill_idx_q  <= 9'h000;
         ecc_idx_q   <= 3'h0;
         ecc_q       <= 32'h00000000;
         stop_q      <= 1'b0;
         med_req_q   <= 1'b0;
         km_q        <= 1'b0;
      end else begin
         med_req_q <= 1'b0;
         km_q      <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (wr_acc && !busy_q && !drq_q) begin
                  case (idx)
                     IDX_FEATURE:    fea_q    <= pwdata[7:0];
                     IDX_SECT_CNT:   cnt_q    <= pwdata[7:0];
                     IDX_SECT_NUM:   snum_q   <= pwdata[7:0];
                     IDX_CYL_LOW:    cyl_lo_q <= pwdata[7:0];
                     IDX_CYL_HIGH:   cyl_hi_q <= pwdata[7:0];
                     IDX_DRIVE_HEAD: dh_q     <= pwdata[7:0];
                     IDX_COMMAND: begin
                        errbit_q   <= 1'b0;
                        corr_q     <= 1'b0;
                        err_q      <= RST_ZERO;
                        stop_q     <= 1'b0;
                        blk_pos_q  <= 9'h000;
                        idx_q      <= 9'h000;
                        ecc_idx_q  <= 3'h0;
                        fill_idx_q <= 9'h000;
                        sect_left_q <= req_count;
                        case (pwdata[7:0])
                           OP_READ_SECT, OP_READ_SECT_NR: begin
                              kind_q <= K_PIO;
                              busy_q <= 1'b1;
                              med_req_q <= 1'b1;
                              state_q <= ST_FILL;
                           end
                           OP_READ_LONG, OP_READ_LONG_NR: begin
                              kind_q <= K_LONG;
                              sect_left_q <= 9'h001;
                              busy_q <= 1'b1;
                              med_req_q <= 1'b1;
                              state_q <= ST_FILL;
                           end
                           OP_READ_BUF: begin
                              kind_q <= K_BUF;
                              sect_left_q <= 9'h001;
                              drq_q <= 1'b1;
                              state_q <= ST_XFER;
                           end
                           OP_READ_MULT: begin
                              if (mult_set_q && mult_en_q) begin
                                 kind_q <= K_MULT;
                                 busy_q <= 1'b1;
                                 med_req_q <= 1'b1;
                                 state_q <= ST_FILL;
                              end else begin
                                 errbit_q <= 1'b1;
                                 err_q <= ERR_ABORT;
                              end
                           end
                           OP_READ_DMA: begin
                              if (!eight_q) begin
                                 kind_q <= K_DMA;
                                 busy_q <= 1'b1;
                                 med_req_q <= 1'b1;
                                 state_q <= ST_FILL;
                              end else begin
                                 errbit_q <= 1'b1;
                                 err_q <= ERR_ABORT;
                              end
                           end
                           OP_KEY_MGMT: begin
                              if (fea_q == FEA_KM_CHANGE && {cyl_hi_q, cyl_lo_q} == KM_GUARD) begin
                                 km_q <= 1'b1;
                              end else begin
                                 errbit_q <= 1'b1;
                                 err_q <= ERR_ABORT;
                              end
                           end
                           default: begin
                              errbit_q <= 1'b1;
                              err_q <= ERR_ABORT;
                           end
                        endcase
                     end
                     default: ;
                  endcase
               end
            end
            ST_FILL: begin
               if (med_word_valid && fill_idx_q < WORDS_PER_SECT) begin
                  fill_idx_q <= fill_idx_q + 9'h001;
               end
               if (med_done) begin
                  ecc_q <= med_ecc;
                  idx_q <= 9'h000;
                  ecc_idx_q <= 3'h0;
                  if (med_err == MED_CORRECTED && kind_q != K_LONG) begin
                     corr_q <= 1'b1;
                  end
                  if (med_err == MED_UNCORRECTABLE && kind_q != K_LONG) begin
                     errbit_q <= 1'b1;
                     err_q <= ERR_UNCORR;
                     if (kind_q == K_MULT) begin
                        stop_q <= 1'b1;
                        busy_q <= 1'b0;
                        drq_q <= 1'b1;
                        state_q <= ST_XFER;
                     end else begin
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                     end
                  end else begin
                     busy_q <= 1'b0;
                     drq_q <= 1'b1;
                     state_q <= ST_XFER;
                  end
               end
            end
            ST_XFER: begin
               if (word_pop) begin
                  idx_q <= idx_q + 9'h001;
               end
               if (ecc_pop) begin
                  ecc_idx_q <= ecc_idx_q + 3'h1;
               end
               if (sector_end) begin
                  drq_q <= 1'b0;
                  if (final_sector || (stop_q && block_end)) begin
                     if (kind_q != K_BUF) begin
                        cnt_q <= cnt_q - 8'h01;
                     end
                     state_q <= ST_IDLE;
                  end else begin
                     sect_left_q <= sect_left_q - 9'h001;
                     cnt_q <= cnt_q - 8'h01;
                     blk_pos_q <= block_end ? 9'h000 : blk_pos_q + 9'h001;
                     busy_q <= 1'b1;
                     fill_idx_q <= 9'h000;
                     med_req_q <= 1'b1;
                     state_q <= ST_FILL;
                     if (dh_q[DH_LBA_BIT]) begin
                        {dh_q[3:0], cyl_hi_q, cyl_lo_q, snum_q} <= lba_next;
                     end else if (snum_q < 8'(CHS_SECTORS)) begin
                        snum_q <= snum_q + 8'h01;
                     end else begin
                        snum_q <= RST_SECT_NUM;
                        if (dh_q[3:0] < 4'(CHS_HEADS - 1)) begin
                           dh_q[3:0] <= dh_q[3:0] + 4'h1;
                        end else begin
                           dh_q[3:0] <= 4'h0;
                           {cyl_hi_q, cyl_lo_q} <= {cyl_hi_q, cyl_lo_q} + 16'h0001;
                        end
                     end
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata           = prdata_q;
   assign pready           = pready_q;
   assign pslverr          = pslverr_q;
   assign dma_request_line = (state_q == ST_XFER) && (kind_q == K_DMA) && drq_q;
   assign dma_data         = dma_data_q;
   assign host_intrq       = irq_q;
   assign med_req          = med_req_q;
   assign med_addr         = {dh_q[3:0], cyl_hi_q, cyl_lo_q, snum_q};
   assign med_lba_mode     = dh_q[DH_LBA_BIT];
   assign km_change_strobe = km_q;

endmodule : ata_read_command_exec

// [src/ata_read_pkg.sv]
// Purpose: Shared constants for the read command group task-file block
// Assumes: APB byte address is four times the register index
// Notes:   Opcodes, field positions, reset values and counts
package ata_read_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [3:0]  IDX_DATA         = 4'h0;
   localparam logic [3:0]  IDX_FEATURE      = 4'h1;
   localparam logic [3:0]  IDX_SECT_CNT     = 4'h2;
   localparam logic [3:0]  IDX_SECT_NUM     = 4'h3;
   localparam logic [3:0]  IDX_CYL_LOW      = 4'h4;
   localparam logic [3:0]  IDX_CYL_HIGH     = 4'h5;
   localparam logic [3:0]  IDX_DRIVE_HEAD   = 4'h6;
   localparam logic [3:0]  IDX_COMMAND      = 4'h7;
   localparam logic [3:0]  IDX_CONFIG       = 4'h8;
   localparam logic [3:0]  IDX_STATUS       = 4'h9;
   localparam logic [3:0]  IDX_ERROR        = 4'ha;

   // ----------------------------------------------------------------
   // Opcodes and guard values
   // ----------------------------------------------------------------
   localparam logic [7:0]  OP_NOP           = 8'h00;
   localparam logic [7:0]  OP_READ_SECT     = 8'h20;
   localparam logic [7:0]  OP_READ_SECT_NR  = 8'h21;
   localparam logic [7:0]  OP_READ_LONG     = 8'h22;
   localparam logic [7:0]  OP_READ_LONG_NR  = 8'h23;
   localparam logic [7:0]  OP_KEY_MGMT      = 8'hb9;
   localparam logic [7:0]  OP_READ_MULT     = 8'hc4;
   localparam logic [7:0]  OP_READ_DMA      = 8'hc8;
   localparam logic [7:0]  OP_READ_BUF      = 8'he4;
   localparam logic [7:0]  FEA_KM_CHANGE    = 8'h81;
   localparam logic [15:0] KM_GUARD         = 16'hb26e;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int          DH_LBA_BIT       = 6;
   localparam int          ST_BUSY_BIT      = 7;
   localparam int          ST_READY_BIT     = 6;
   localparam int          ST_DRQ_BIT       = 3;
   localparam int          ST_CORR_BIT      = 2;
   localparam int          ST_ERR_BIT       = 0;
   localparam int          CFG_EIGHT_BIT    = 0;
   localparam int          CFG_MULT_EN_BIT  = 1;
   localparam int          CFG_MULT_SET_BIT = 2;
   localparam int          CFG_BLK_LSB      = 8;
   localparam logic [7:0]  ERR_ABORT        = 8'h04;
   localparam logic [7:0]  ERR_UNCORR       = 8'h40;

   // ----------------------------------------------------------------
   // Counts and reset values
   // ----------------------------------------------------------------
   localparam logic [8:0]  WORDS_PER_SECT   = 9'h100;
   localparam logic [8:0]  MAX_SECTORS      = 9'h100;
   localparam logic [2:0]  ECC_BYTES        = 3'h4;
   localparam logic [7:0]  RST_DRIVE_HEAD   = 8'ha0;
   localparam logic [7:0]  RST_SECT_NUM     = 8'h01;
   localparam logic [7:0]  RST_ZERO         = 8'h00;

   typedef enum logic [1:0] {MED_OK, MED_CORRECTED, MED_UNCORRECTABLE, MED_RSVD} med_err_e;
   typedef enum {ST_IDLE, ST_FILL, ST_XFER} seq_state_e;
   typedef enum {K_PIO, K_BUF, K_LONG, K_MULT, K_DMA} cmd_kind_e;

endpackage : ata_read_pkg

// [verif/ata_read_chk_sva.sv]
// Purpose: Port checker for the read command block
// Assumes: Bench writes task file only while idle
// Notes:   Bound to the top module
`timescale 1ns/1ps
module ata_read_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        dma_request_line,
   input wire logic        host_intrq,
   input wire logic        med_req,
   input wire logic        med_lba_mode,
   input wire logic        km_change_strobe,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [27:0] med_addr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable && pready && pwrite;
   chk_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_sect_load: assert property (acc && paddr == 12'h00c |=> med_addr[7:0] == $past(pwdata[7:0]))
      else $error("sector number not in address");
   chk_cyl_load: assert property (acc && paddr == 12'h014 |=> med_addr[23:16] == $past(pwdata[7:0]))
      else $error("cylinder high not in address");
   chk_head_mode: assert property (acc && paddr == 12'h018 |=> med_lba_mode == $past(pwdata[6])
      && med_addr[27:24] == $past(pwdata[3:0])) else $error("drive head field wrong");
   chk_fetch_start: assert property (acc && paddr == 12'h01c && pwdata[7:0] == 8'h20 |=> med_req)
      else $error("no fetch after read command");
   chk_nop_idle: assert property (acc && paddr == 12'h01c && pwdata[7:0] == 8'h00 |=> !med_req [*3])
      else $error("fetch after no-operation");
   chk_dma_irq: assert property ($rose(host_intrq) |-> !dma_request_line)
      else $error("interrupt while DMA data pending");
   chk_key_pulse: assert property (km_change_strobe |=> !km_change_strobe)
      else $error("key strobe longer than one cycle");
   cov_key: cover property (km_change_strobe);
   cov_dma: cover property ($fell(dma_request_line));
   cov_err: cover property (pslverr);
endmodule : ata_read_chk
bind ata_read_command_exec ata_read_chk i_chk (.*);

// [verif/media_model.sv]
// Purpose: Media side responder
// Assumes: One sector fill per fetch pulse
// Notes:   Word value is index xor a500
`timescale 1ns/1ps
module media_model (
   input wire logic pclk,
   input wire logic med_req,
   output logic [15:0] med_word,
   output logic        med_word_valid,
   output logic        med_done
);
   initial {med_word, med_word_valid, med_done} = '0;
   always @(posedge pclk) if (med_req) begin
      for (int i = 0; i < 256; i++) begin
         med_word <= 16'(i) ^ 16'ha500;
         med_word_valid <= 1'b1;
         @(posedge pclk);
      end
      med_word <= ~med_word;
      med_word_valid <= 1'b0;
      med_done <= 1'b1;
      @(posedge pclk);
      med_done <= 1'b0;
   end
endmodule : media_model

// [verif/test_ata_read_command_exec.sv]
// Purpose: Self-checking bench for the read command block
// Assumes: Register byte address is index times four
// Notes:   Media model feeds every fill
`timescale 1ns/1ps
module test_ata_read_command_exec;
   import ata_read_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ack_n = 1, strb_n = 1, serr, irq_q = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] dma_data, med_word;
   logic [27:0] med_addr;
   logic        pready, pslverr, dma_request_line, host_intrq, med_req, med_lba_mode, mvalid, mdone, km;
   int          failures = 0, cmp_count = 0, km_cnt = 0, irq_cnt = 0;
   med_err_e    merr = MED_OK;
   ata_read_command_exec i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .dma_request_line, .dma_acknowledge_n(ack_n), .io_read_strobe_n(strb_n), .dma_data, .host_intrq,
      .med_req, .med_addr, .med_lba_mode, .med_word, .med_word_valid(mvalid), .med_done(mdone),
      .med_ecc(32'h0), .med_err(merr), .km_change_strobe(km));
   media_model i_media (.pclk, .med_req, .med_word, .med_word_valid(mvalid), .med_done(mdone));
   initial forever #2 pclk = ~pclk;
   always @(posedge pclk) begin
      km_cnt += int'(km);
      irq_cnt += int'(host_intrq & !irq_q);
      irq_q <= host_intrq;
   end
   task automatic chk(input string n, input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
      int t = 0;
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (!pready && ++t < 20);
      rd = prdata;
      serr = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
      if (t >= 20) failures++;
   endtask : apb
   task automatic poll(input int b);
      int t = 0;
      do apb(0, 12'h024, 0); while (!rd[b] && ++t < 500);
      chk("status", rd[b], 1'b1);
   endtask : poll
   task automatic t_basic;
      chk("reset_addr", med_addr, 28'h1);
      apb(0, 12'h02c, 0);
      chk("unmapped", serr, 1'b1);
      apb(1, 12'h01c, 32'h00);
      apb(0, 12'h028, 0);
      chk("nop_err", rd[7:0], ERR_ABORT);
      apb(1, 12'h01c, 32'hc4);
      apb(0, 12'h028, 0);
      chk("mult_off", rd[7:0], ERR_ABORT);
   endtask : t_basic
   task automatic t_key;
      apb(1, 12'h004, 32'h81); apb(1, 12'h014, 32'hb2); apb(1, 12'h010, 32'h00); apb(1, 12'h01c, 32'hb9);
      apb(0, 12'h028, 0);
      chk("key_guard", rd[7:0], ERR_ABORT);
      chk("key_none", km_cnt, 0);
      apb(1, 12'h010, 32'h6e); apb(1, 12'h01c, 32'hb9); apb(0, 12'h024, 0);
      chk("key_ok", km_cnt, 1);
   endtask : t_key
   task automatic t_pio;
      int i0;
      apb(1, 12'h018, 32'he5); apb(1, 12'h014, 32'h12); apb(1, 12'h010, 32'h34); apb(1, 12'h00c, 32'h56);
      i0 = irq_cnt;
      apb(1, 12'h008, 32'h1); apb(1, 12'h01c, 32'h20);
      chk("lba_addr", {med_lba_mode, med_addr}, 29'h15123456);
      poll(ST_DRQ_BIT);
      chk("pio_irq", irq_cnt - i0, 1);
      for (int i = 0; i < 256; i++) begin
         apb(0, 12'h000, 0);
         chk("pio_word", rd[15:0], 16'(i) ^ 16'ha500);
      end
      apb(0, 12'h024, 0);
      chk("pio_drq", rd[ST_DRQ_BIT], 1'b0);
   endtask : t_pio
   task automatic t_dma;
      int t, i0;
      apb(1, 12'h020, 32'h1); apb(1, 12'h01c, 32'hc8); apb(0, 12'h028, 0);
      chk("dma8", rd[7:0], ERR_ABORT);
      apb(1, 12'h020, 32'h0); apb(0, 12'h024, 0); apb(1, 12'h008, 32'h2);
      i0 = irq_cnt;
      apb(1, 12'h01c, 32'hc8);
      ack_n <= 0;
      for (int i = 0; i < 512; i++) begin
         t = 0;
         while (!dma_request_line && ++t < 2000) @(posedge pclk);
         chk("dma_req", dma_request_line, 1'b1);
         strb_n <= 0; repeat (3) @(posedge pclk);
         strb_n <= 1; repeat (5) @(posedge pclk);
         chk("dma_word", dma_data, 16'(i % 256) ^ 16'ha500);
      end
      ack_n <= 1; repeat (10) @(posedge pclk);
      chk("dma_irq", irq_cnt - i0, 1);
      chk("dma_end", {dma_request_line, med_addr}, 29'h05123457);
   endtask : t_dma
   task automatic t_err;
      merr <= MED_UNCORRECTABLE;
      apb(1, 12'h01c, 32'h20);
      poll(ST_READY_BIT);
      merr <= MED_OK;
      apb(0, 12'h028, 0);
      chk("err_code", rd[7:0], ERR_UNCORR);
      chk("err_addr", med_addr, 28'h5123457);
   endtask : t_err
   task automatic t_buf;
      apb(1, 12'h01c, 32'he4);
      for (int i = 0; i < 256; i++) begin
         apb(0, 12'h000, 0);
         chk("buf_word", rd[15:0], 16'(i) ^ 16'ha500);
      end
   endtask : t_buf
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      t_basic; t_key; t_pio; t_dma; t_err; t_buf;
      finish_test;
   end
   initial begin
      #200000;
      failures++;
      finish_test;
   end
endmodule : test_ata_read_command_exec
